// >>> pcp_pixel_correction.sv
// Pixel correction pipeline: black level, white balance, gamma, LUT, sharpening.
// Assumes a same-clock pixel stream with frame and line marks and an APB master.
// Operation
// - Red and blue are scaled by ratios against green; green gain stays one.
// - Red and blue ratios at unity pass pixels unchanged.
// - One-shot auto balance iterates some frames, then switches itself off.
// - Continuous auto balance keeps adjusting while colours look imbalanced.
// - Gamma output is input raised to the programmed exponent.
// - Gamma off leaves pixel data linear.
// - Gamma is applied before the pixel lookup table.
// - Sharpening is off after reset until software enables it.
// - Amount and threshold settings only matter while sharpening is on.
// - Only gradients above the threshold are sharpened.
// - Threshold is a fraction up to a quarter; larger acts as a quarter.
// - Auto threshold follows the camera noise level.
// - Zero amount changes nothing; negative smooths; positive boosts edges.
// - Amount limited to eight times boost and one times smoothing.
// - Sharpening amount resets to two.
// - Digital black level is added to digitized pixels.
// - Software writes the total; analog and digital portions are read only.
//
// Design decisions made here: the register offsets and the APB slave port.
`timescale 1ns/1ps
`default_nettype none

module pcp_pixel_correction (
	input wire logic clk_i,
	input wire logic arst_n_i,
	input wire logic psel_i,
	input wire logic penable_i,
	input wire logic pwrite_i,
	input wire logic [7:0] paddr_i,
	input wire logic [31:0] pwdata_i,
	input wire logic [3:0] pstrb_i,
	output logic pready_o,
	output logic [31:0] prdata_o,
	output logic pslverr_o,
	input wire pcp_pkg::pcp_pix_t pix_i,
	input wire logic [9:0] noise_level_i,
	output pcp_pkg::pcp_pix_t pix_o,
	output logic [11:0] analog_black_o
);

	typedef struct packed {
		logic power_curve_on;
		logic lut_on;
		logic sharp_on;
		logic sharp_auto;
		pcp_pkg::pcp_wb_mode_t wb_mode;
		logic [3:0] once_cnt;
		logic [11:0] black_total;
		logic [11:0] wb_r;
		logic [11:0] wb_b;
		logic [7:0] gexp;
		logic [8:0] amt;
		logic [7:0] thr;
		logic [9:0] lut_addr;
		pcp_pkg::pcp_cfg_t frm;
		logic [11:0] s1_bl;
		logic [11:0] s2_r;
		logic [11:0] s2_b;
		logic s3_on;
		logic [7:0] s3_exp;
		logic s4_lut;
		logic s5_on;
		logic [9:0] s5_thr;
		logic [8:0] s5_amt;
		pcp_pkg::pcp_pix_t p1;
		pcp_pkg::pcp_pix_t p2;
		pcp_pkg::pcp_pix_t p4;
		pcp_pkg::pcp_pix_t ctr;
		pcp_pkg::pcp_pix_t out;
		logic [9:0] left;
		logic left_ok;
		logic [35:0] sum_r;
		logic [35:0] sum_g;
		logic [35:0] sum_b;
		logic [11:0] analog;
		logic pready;
		logic [31:0] prdata;
		logic pslverr;
	} pcp_state_t;

	pcp_state_t st_reg;
	pcp_state_t st_next;
	logic [9:0] lut_mem [0:1023];
	logic lut_we;
	logic [9:0] lut_wdata;
	pcp_pkg::pcp_pix_t p3;
	logic g_on;
	logic [7:0] g_exp;

	// Clamp a signed result into the pixel range
	function automatic logic [9:0] pcp_sat(input logic signed [23:0] v);
		if (v < 0) begin
			pcp_sat = 10'h000;
		end else if (v > $signed({14'h0000, pcp_pkg::PIX_FULL})) begin
			pcp_sat = pcp_pkg::PIX_FULL;
		end else begin
			pcp_sat = v[9:0];
		end
	endfunction

	// Step a ratio toward balance; Bayer mosaic has two greens per red or blue
	function automatic logic [11:0] pcp_nudge(input logic [11:0] ratio,
			input logic [35:0] sc, input logic [35:0] sg);
		logic [36:0] twice;
		logic [36:0] tol;
		twice = {sc, 1'b0};
		tol = {6'h00, sg[35:5]};
		pcp_nudge = ratio;
		if (sg != 36'h0) begin
			if (twice > {1'b0, sg} + tol && ratio > pcp_pkg::RATIO_MIN) begin
				pcp_nudge = ratio - pcp_pkg::RATIO_STEP;
			end else if (twice + tol < {1'b0, sg} && ratio < pcp_pkg::RATIO_MAX) begin
				pcp_nudge = ratio + pcp_pkg::RATIO_STEP;
			end
		end
	endfunction

	pcp_power_curve u_power (
		.clk_i(clk_i),
		.arst_n_i(arst_n_i),
		.en_i(g_on),
		.exp_i(g_exp),
		.pix_i(st_reg.p2),
		.pix_o(p3)
	);

	always_comb begin
		pcp_pkg::pcp_cfg_t shadow;
		logic [11:0] bl;
		logic [11:0] gain;
		logic [21:0] wprod;
		logic emit;
		logic [9:0] rdat;
		logic [9:0] ldat;
		logic signed [12:0] lap;
		logic [12:0] mag;
		logic signed [21:0] sprod;
		logic [10:0] noise2;
		logic [31:0] rdv;
		logic [31:0] wd;
		logic hit;
		logic ro;
		logic acc_wr;
		logic signed [8:0] av;
		st_next = st_reg;
		lut_we = 1'b0;
		lut_wdata = 10'h000;
		// Software settings as they would apply to the next frame
		shadow.power_curve_on = st_reg.power_curve_on;
		shadow.lut_on = st_reg.lut_on;
		shadow.sharp_on = st_reg.sharp_on;
		shadow.sharp_auto = st_reg.sharp_auto;
		shadow.analog = (st_reg.black_total > pcp_pkg::ANALOG_MAX) ?
			pcp_pkg::ANALOG_MAX : st_reg.black_total;
		shadow.bl_dig = st_reg.black_total - shadow.analog;
		shadow.wb_r = st_reg.wb_r;
		shadow.wb_b = st_reg.wb_b;
		shadow.gexp = st_reg.gexp;
		shadow.amt = st_reg.amt;
		shadow.thr = st_reg.thr;
		if (pix_i.valid && pix_i.sof) begin
			st_next.frm = shadow;
			st_next.analog = shadow.analog;
		end
		// Black level offset
		bl = (pix_i.valid && pix_i.sof) ? shadow.bl_dig : st_reg.s1_bl;
		st_next.s1_bl = bl;
		st_next.p1 = pix_i;
		st_next.p1.data = pcp_sat(24'(pix_i.data) + 24'(bl));
		// White balance gains
		if (st_reg.p1.valid && st_reg.p1.sof) begin
			st_next.s2_r = st_reg.frm.wb_r;
			st_next.s2_b = st_reg.frm.wb_b;
		end
		case (st_reg.p1.chan)
			pcp_pkg::CH_RED: gain = st_next.s2_r;
			pcp_pkg::CH_BLUE: gain = st_next.s2_b;
			default: gain = pcp_pkg::RATIO_UNITY;
		endcase
		wprod = st_reg.p1.data * gain;
		st_next.p2 = st_reg.p1;
		st_next.p2.data = pcp_sat(24'(wprod[21:8]));
		// Gamma settings follow the frame mark into the power stage
		if (st_reg.p2.valid && st_reg.p2.sof) begin
			st_next.s3_on = st_reg.frm.power_curve_on;
			st_next.s3_exp = st_reg.frm.gexp;
		end
		g_on = st_next.s3_on;
		g_exp = st_next.s3_exp;
		// Lookup table after the power curve
		if (p3.valid && p3.sof) begin
			st_next.s4_lut = st_reg.frm.lut_on;
		end
		st_next.p4 = p3;
		if (st_next.s4_lut) begin
			st_next.p4.data = lut_mem[p3.data];
		end
		// Sharpening over a three-pixel horizontal window
		emit = st_reg.ctr.valid && (st_reg.ctr.eol || st_reg.p4.valid);
		rdat = st_reg.ctr.eol ? st_reg.ctr.data : st_reg.p4.data;
		ldat = st_reg.left_ok ? st_reg.left : st_reg.ctr.data;
		lap = $signed({2'b00, st_reg.ctr.data, 1'b0}) - $signed({3'b000, ldat})
			- $signed({3'b000, rdat});
		mag = (lap < 0) ? 13'(-lap) : 13'(lap);
		sprod = $signed(st_reg.s5_amt) * lap;
		st_next.out = '0;
		if (emit) begin
			st_next.out = st_reg.ctr;
			if (st_reg.s5_on && mag > {3'b000, st_reg.s5_thr}) begin
				st_next.out.data = pcp_sat(24'(st_reg.ctr.data) + 24'(sprod >>> 5));
			end
			st_next.left = st_reg.ctr.data;
			st_next.left_ok = !st_reg.ctr.eol;
		end
		noise2 = {noise_level_i, 1'b0};
		if (!st_reg.ctr.valid || emit) begin
			st_next.ctr = st_reg.p4;
			if (st_reg.p4.valid && st_reg.p4.sof) begin
				st_next.s5_on = st_reg.frm.sharp_on;
				st_next.s5_amt = st_reg.frm.amt;
				if (st_reg.frm.sharp_auto) begin
					st_next.s5_thr = (noise2 > {1'b0, pcp_pkg::THR_PIX_MAX}) ?
						pcp_pkg::THR_PIX_MAX : noise2[9:0];
				end else if (st_reg.frm.thr > pcp_pkg::THR_MAX) begin
					st_next.s5_thr = {pcp_pkg::THR_MAX, 2'b00};
				end else begin
					st_next.s5_thr = {st_reg.frm.thr, 2'b00};
				end
			end
		end
		// Colour statistics and automatic balance
		if (st_reg.p2.valid) begin
			if (st_reg.p2.sof) begin
				if (st_reg.wb_mode != pcp_pkg::WB_OFF) begin
					st_next.wb_r = pcp_nudge(st_reg.wb_r, st_reg.sum_r, st_reg.sum_g);
					st_next.wb_b = pcp_nudge(st_reg.wb_b, st_reg.sum_b, st_reg.sum_g);
				end
				if (st_reg.wb_mode == pcp_pkg::WB_ONCE) begin
					st_next.once_cnt = st_reg.once_cnt - 4'h1;
					if (st_reg.once_cnt <= 4'h1) begin
						st_next.wb_mode = pcp_pkg::WB_OFF;
					end
				end
				st_next.sum_r = '0;
				st_next.sum_g = '0;
				st_next.sum_b = '0;
			end
			case (st_reg.p2.chan)
				pcp_pkg::CH_RED: st_next.sum_r = st_next.sum_r + 36'(st_reg.p2.data);
				pcp_pkg::CH_GREEN: st_next.sum_g = st_next.sum_g + 36'(st_reg.p2.data);
				pcp_pkg::CH_BLUE: st_next.sum_b = st_next.sum_b + 36'(st_reg.p2.data);
				default: st_next.sum_g = st_next.sum_g;
			endcase
		end
		// APB slave: answer one cycle after setup, software write wins
		hit = 1'b1;
		ro = 1'b0;
		case (paddr_i)
			pcp_pkg::OFS_CTRL: rdv = 32'({st_reg.wb_mode, st_reg.sharp_auto,
				st_reg.sharp_on, st_reg.lut_on, st_reg.power_curve_on});
			pcp_pkg::OFS_BLACK_TOTAL: rdv = 32'(st_reg.black_total);
			pcp_pkg::OFS_BLACK_SPLIT: begin
				rdv = 32'(shadow.analog) | (32'(shadow.bl_dig) << pcp_pkg::SPLIT_DIG_LSB);
				ro = 1'b1;
			end
			pcp_pkg::OFS_WB_RED: rdv = 32'(st_reg.wb_r);
			pcp_pkg::OFS_WB_BLUE: rdv = 32'(st_reg.wb_b);
			pcp_pkg::OFS_GAMMA_EXP: rdv = 32'(st_reg.gexp);
			pcp_pkg::OFS_SHARP_AMT: rdv = 32'(st_reg.amt);
			pcp_pkg::OFS_SHARP_THR: rdv = 32'(st_reg.thr);
			pcp_pkg::OFS_LUT_ADDR: rdv = 32'(st_reg.lut_addr);
			pcp_pkg::OFS_LUT_DATA: rdv = 32'(lut_mem[st_reg.lut_addr]);
			pcp_pkg::OFS_STATUS: begin
				rdv = 32'(st_reg.once_cnt) | (32'(st_reg.s5_thr) << pcp_pkg::STATUS_THR_LSB);
				ro = 1'b1;
			end
			default: begin
				rdv = 32'h0000_0000;
				hit = 1'b0;
			end
		endcase
		for (int i = 0; i < 4; i++) begin
			wd[i*8 +: 8] = pstrb_i[i] ? pwdata_i[i*8 +: 8] : rdv[i*8 +: 8];
		end
		st_next.pready = psel_i && !penable_i;
		st_next.pslverr = psel_i && !penable_i && (!hit || (pwrite_i && ro));
		st_next.prdata = (psel_i && !penable_i && !pwrite_i && hit) ? rdv : 32'h0000_0000;
		acc_wr = psel_i && penable_i && pwrite_i && st_reg.pready && !st_reg.pslverr;
		av = $signed(wd[8:0]);
		if (acc_wr) begin
			case (paddr_i)
				pcp_pkg::OFS_CTRL: begin
					st_next.power_curve_on = wd[pcp_pkg::CTRL_POWER_BIT];
					st_next.lut_on = wd[pcp_pkg::CTRL_LUT_BIT];
					st_next.sharp_on = wd[pcp_pkg::CTRL_SHARP_BIT];
					st_next.sharp_auto = wd[pcp_pkg::CTRL_SAUTO_BIT];
					st_next.wb_mode = (wd[pcp_pkg::CTRL_WB_LSB +: 2] == 2'h3) ? pcp_pkg::WB_OFF :
						pcp_pkg::pcp_wb_mode_t'(wd[pcp_pkg::CTRL_WB_LSB +: 2]);
					if (st_next.wb_mode == pcp_pkg::WB_ONCE) begin
						st_next.once_cnt = pcp_pkg::ONCE_ITER;
					end
				end
				pcp_pkg::OFS_BLACK_TOTAL: st_next.black_total = wd[11:0];
				pcp_pkg::OFS_WB_RED: st_next.wb_r = wd[11:0];
				pcp_pkg::OFS_WB_BLUE: st_next.wb_b = wd[11:0];
				pcp_pkg::OFS_GAMMA_EXP: st_next.gexp = wd[7:0];
				pcp_pkg::OFS_SHARP_AMT: begin
					if (av > $signed(pcp_pkg::AMT_MAX)) begin
						st_next.amt = pcp_pkg::AMT_MAX;
					end else if (av < $signed(pcp_pkg::AMT_MIN)) begin
						st_next.amt = pcp_pkg::AMT_MIN;
					end else begin
						st_next.amt = wd[8:0];
					end
				end
				pcp_pkg::OFS_SHARP_THR: st_next.thr = wd[7:0];
				pcp_pkg::OFS_LUT_ADDR: st_next.lut_addr = wd[9:0];
				pcp_pkg::OFS_LUT_DATA: begin
					lut_we = 1'b1;
					lut_wdata = wd[9:0];
					st_next.lut_addr = st_reg.lut_addr + 10'h001;
				end
				default: lut_we = 1'b0;
			endcase
		end
	end

	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			st_reg <= '0;
			st_reg.black_total <= pcp_pkg::RST_BLACK;
			st_reg.wb_r <= pcp_pkg::RST_RATIO;
			st_reg.wb_b <= pcp_pkg::RST_RATIO;
			st_reg.gexp <= pcp_pkg::RST_GEXP;
			st_reg.amt <= pcp_pkg::RST_AMT;
			st_reg.thr <= pcp_pkg::RST_THR;
			st_reg.sharp_on <= 1'b0;
			st_reg.s2_r <= pcp_pkg::RST_RATIO;
			st_reg.s2_b <= pcp_pkg::RST_RATIO;
			st_reg.s3_exp <= pcp_pkg::RST_GEXP;
			st_reg.s5_amt <= pcp_pkg::RST_AMT;
		end else begin
			st_reg <= st_next;
		end
	end

	always_ff @(posedge clk_i) begin
		if (lut_we) begin
			lut_mem[st_reg.lut_addr] <= lut_wdata;
		end
	end

	assign pready_o = st_reg.pready;
	assign prdata_o = st_reg.prdata;
	assign pslverr_o = st_reg.pslverr;
	assign pix_o = st_reg.out;
	assign analog_black_o = st_reg.analog;

endmodule

`default_nettype wire

// >>> pcp_pixel_correction_props.sv
// Checker on the top ports of the pixel correction pipeline.
// Assumes it is bound into pcp_pixel_correction by the testbench.
`timescale 1ns/1ps
`default_nettype none
module pcp_pixel_correction_props (
	input wire logic clk_i,
	input wire logic arst_n_i,
	input wire logic psel_i,
	input wire logic penable_i,
	input wire logic pwrite_i,
	input wire logic [7:0] paddr_i,
	input wire logic pready_o,
	input wire logic [31:0] prdata_o,
	input wire logic pslverr_o,
	input wire pcp_pkg::pcp_pix_t pix_i,
	input wire pcp_pkg::pcp_pix_t pix_o,
	input wire logic [11:0] analog_black_o
);
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!arst_n_i);
	logic acc;
	assign acc = psel_i && penable_i && pready_o;
	a_ready_setup: assert property (psel_i && !penable_i |=> pready_o)
		else $error("no ready after setup");
	a_ready_pulse: assert property (pready_o |=> !pready_o)
		else $error("ready longer than one cycle");
	a_ready_access: assert property (pready_o |-> psel_i && penable_i)
		else $error("ready outside access");
	a_rdata_idle: assert property (!pready_o |-> prdata_o == 32'h0000_0000)
		else $error("read data without ready");
	a_split_wr: assert property (acc && pwrite_i &&
		paddr_i == pcp_pkg::OFS_BLACK_SPLIT |-> pslverr_o)
		else $error("split write accepted");
	a_bad_addr: assert property (acc && (paddr_i > pcp_pkg::OFS_STATUS || paddr_i[1:0] != 2'b00)
		|-> pslverr_o && prdata_o == 32'h0000_0000)
		else $error("bad address accepted");
	a_analog_sof: assert property ($changed(analog_black_o) |->
		$past(pix_i.valid) && $past(pix_i.sof) && analog_black_o <= pcp_pkg::ANALOG_MAX)
		else $error("analog portion changed wrongly");
	a_eol_lat: assert property (pix_i.valid && pix_i.eol |-> ##6 pix_o.valid)
		else $error("line end pixel late");
endmodule
`default_nettype wire

// >>> pcp_pixel_correction_test.sv
// Self-checking bench for the pixel correction pipeline.
// Assumes the sensor model feeds pixels and this module masters APB.
`timescale 1ns/1ps
`default_nettype none
module pcp_pixel_correction_test;
	typedef logic [9:0] pcp_row_t [8];
	logic clk = 1'b0;
	logic arst_n = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0000_0000;
	logic [31:0] prdata, rd;
	logic pready, pslverr, err;
	logic [9:0] noise = 10'h03c;
	logic [11:0] analog;
	pcp_pkg::pcp_pix_t src_pix, pix_out;
	int error_cnt = 0;
	int cmp_count = 0;
	logic [9:0] outq [$];
	pcp_row_t shp = '{10'h064, 10'h064, 10'h064, 10'h12c, 10'h064, 10'h064, 10'h06e, 10'h064};
	pcp_row_t idn = '{10'h068, 10'h068, 10'h068, 10'h130, 10'h068, 10'h068, 10'h072, 10'h068};
	pcp_row_t e0 = '{10'h068, 10'h068, 10'h000, 10'h2c0, 10'h000, 10'h068, 10'h072, 10'h068};
	pcp_row_t e1 = '{10'h068, 10'h068, 10'h068, 10'h2c0, 10'h068, 10'h068, 10'h072, 10'h068};
	pcp_row_t e4 = '{10'h068, 10'h068, 10'h0cc, 10'h068, 10'h0cc, 10'h068, 10'h072, 10'h068};
	pcp_row_t wbe = '{10'h0d0, 10'h068, 10'h068, 10'h034, 10'h0d0, 10'h068, 10'h068, 10'h034};
	pcp_row_t wbc = '{10'h0c8, 10'h064, 10'h064, 10'h064, 10'h0c8, 10'h064, 10'h064, 10'h064};
	pcp_row_t byr = '{10'h000, 10'h001, 10'h001, 10'h002, 10'h000, 10'h001, 10'h001, 10'h002};
	pcp_row_t wbv = '{default: 10'h064};
	pcp_row_t gch = '{default: 10'h001};
	pcp_row_t gin = '{10'h0fc, 10'h03c, 10'h0fc, 10'h03c, 10'h0fc, 10'h03c, 10'h0fc, 10'h03c};
	pcp_row_t gex = '{10'h050, 10'h0a0, 10'h050, 10'h0a0, 10'h050, 10'h0a0, 10'h050, 10'h0a0};
	pcp_row_t s_exp [5];
	logic [31:0] s_ctrl [5] = '{32'h0000_0004, 32'h0000_0004, 32'h0000_000c, 32'h0000_0004,
		32'h0000_0004};
	logic [31:0] s_amt [5] = '{32'h0000_0020, 32'h0000_0020, 32'h0000_0020, 32'h0000_0000,
		32'h0000_01f0};
	logic [31:0] s_thr [5] = '{32'h0000_0008, 32'h0000_00ff, 32'h0000_00ff, 32'h0000_0008,
		32'h0000_0008};

	pcp_pixel_correction uut (.clk_i(clk), .arst_n_i(arst_n), .psel_i(psel), .penable_i(penable),
		.pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .pstrb_i(4'hf), .pready_o(pready),
		.prdata_o(prdata), .pslverr_o(pslverr), .pix_i(src_pix), .noise_level_i(noise),
		.pix_o(pix_out), .analog_black_o(analog));
	pcp_sensor_model src (.clk_i(clk), .pix_o(src_pix));

	initial begin
		forever #4 clk = ~clk;
	end
	always @(posedge clk) begin
		if (pix_out.valid === 1'b1) outq.push_back(pix_out.data);
	end

	task automatic final_report();
		$display("errors %0d compares %0d", error_cnt, cmp_count);
		if (error_cnt == 0 && cmp_count > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask
	task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			error_cnt++;
			$display("[ERR] %s expected %h seen %h", name, exp, seen);
		end
	endtask
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		do begin
			@(posedge clk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (pready !== 1'b1) begin
			error_cnt++;
			final_report();
		end
	endtask
	task automatic rdc(input logic [7:0] a, input logic [31:0] exp, input string name);
		apb(1'b0, a, 32'h0000_0000);
		check(name, rd, exp);
	endtask
	task automatic frame(input pcp_row_t v, input pcp_row_t c, input pcp_row_t e, input bit cmp);
		int n;
		n = 0;
		outq.delete();
		src.send_frame(v, c);
		while (outq.size() < 8 && n < 100) begin
			@(posedge clk);
			n++;
		end
		if (outq.size() < 8) begin
			error_cnt++;
			final_report();
		end
		for (int i = 0; i < 8; i++) begin
			if (cmp) check("pixel", {22'h0, outq[i]}, {22'h0, e[i]});
		end
		repeat (4) @(posedge clk);
	endtask

	initial begin
		s_exp = '{e0, e1, e0, idn, e4};
		repeat (3) @(posedge clk);
		arst_n <= 1'b1;
		rdc(pcp_pkg::OFS_CTRL, 32'h0000_0000, "ctrl");
		rdc(pcp_pkg::OFS_SHARP_AMT, 32'h0000_0020, "amount");
		rdc(pcp_pkg::OFS_WB_RED, 32'h0000_0100, "red ratio");
		apb(1'b1, pcp_pkg::OFS_BLACK_TOTAL, 32'h0000_0104);
		rdc(pcp_pkg::OFS_BLACK_SPLIT, 32'h0004_0100, "split");
		apb(1'b1, pcp_pkg::OFS_BLACK_SPLIT, 32'h0000_0000);
		check("split write", {31'h0, err}, 32'h0000_0001);
		apb(1'b0, 8'h30, 32'h0000_0000);
		check("unmapped", {31'h0, err}, 32'h0000_0001);
		frame(shp, gch, idn, 1'b1);
		check("analog", {20'h0, analog}, 32'h0000_0100);
		apb(1'b1, pcp_pkg::OFS_SHARP_AMT, 32'h0000_00c0);
		rdc(pcp_pkg::OFS_SHARP_AMT, 32'h0000_0080, "amount max");
		apb(1'b1, pcp_pkg::OFS_SHARP_AMT, 32'h0000_01c0);
		rdc(pcp_pkg::OFS_SHARP_AMT, 32'h0000_01f0, "amount min");
		for (int k = 0; k < 5; k++) begin
			apb(1'b1, pcp_pkg::OFS_CTRL, s_ctrl[k]);
			apb(1'b1, pcp_pkg::OFS_SHARP_AMT, s_amt[k]);
			apb(1'b1, pcp_pkg::OFS_SHARP_THR, s_thr[k]);
			frame(shp, gch, s_exp[k], 1'b1);
		end
		noise <= 10'h070;
		apb(1'b1, pcp_pkg::OFS_CTRL, 32'h0000_000c);
		apb(1'b1, pcp_pkg::OFS_SHARP_AMT, 32'h0000_0020);
		frame(shp, gch, e1, 1'b1);
		rdc(pcp_pkg::OFS_STATUS, 32'h00e0_0000, "threshold");
		apb(1'b1, pcp_pkg::OFS_CTRL, 32'h0000_0000);
		apb(1'b1, pcp_pkg::OFS_WB_RED, 32'h0000_0200);
		apb(1'b1, pcp_pkg::OFS_WB_BLUE, 32'h0000_0080);
		frame(wbv, byr, wbe, 1'b1);
		apb(1'b1, pcp_pkg::OFS_WB_RED, 32'h0000_0100);
		apb(1'b1, pcp_pkg::OFS_WB_BLUE, 32'h0000_0100);
		apb(1'b1, pcp_pkg::OFS_CTRL, 32'h0000_0010);
		apb(1'b0, pcp_pkg::OFS_STATUS, 32'h0000_0000);
		check("iterations", {28'h0, rd[3:0]}, 32'h0000_0008);
		repeat (10) frame(wbv, byr, idn, 1'b0);
		rdc(pcp_pkg::OFS_CTRL, 32'h0000_0000, "auto off");
		rdc(pcp_pkg::OFS_WB_RED, 32'h0000_00fc, "red once");
		rdc(pcp_pkg::OFS_WB_BLUE, 32'h0000_0104, "blue once");
		apb(1'b1, pcp_pkg::OFS_CTRL, 32'h0000_0020);
		repeat (4) frame(wbc, byr, idn, 1'b0);
		apb(1'b0, pcp_pkg::OFS_WB_RED, 32'h0000_0000);
		check("red lowered", {31'h0, rd < 32'h0000_0100}, 32'h0000_0001);
		rdc(pcp_pkg::OFS_WB_BLUE, 32'h0000_0104, "blue kept");
		apb(1'b1, pcp_pkg::OFS_LUT_ADDR, 32'h0000_0100);
		apb(1'b1, pcp_pkg::OFS_LUT_DATA, 32'h0000_00a0);
		apb(1'b1, pcp_pkg::OFS_LUT_ADDR, 32'h0000_0200);
		apb(1'b1, pcp_pkg::OFS_LUT_DATA, 32'h0000_0050);
		rdc(pcp_pkg::OFS_LUT_ADDR, 32'h0000_0201, "lut addr");
		apb(1'b1, pcp_pkg::OFS_LUT_ADDR, 32'h0000_0100);
		rdc(pcp_pkg::OFS_LUT_DATA, 32'h0000_00a0, "lut data");
		apb(1'b1, pcp_pkg::OFS_GAMMA_EXP, 32'h0000_0020);
		apb(1'b1, pcp_pkg::OFS_CTRL, 32'h0000_0003);
		frame(gin, gch, gex, 1'b1);
		final_report();
	end
endmodule

bind pcp_pixel_correction pcp_pixel_correction_props u_props (.clk_i(clk_i), .arst_n_i(arst_n_i),
	.psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
	.pready_o(pready_o), .prdata_o(prdata_o), .pslverr_o(pslverr_o), .pix_i(pix_i),
	.pix_o(pix_o), .analog_black_o(analog_black_o));
`default_nettype wire

// >>> pcp_pkg.sv
// Shared constants and types of the pixel correction pipeline.
// Assumes one pixel clock; register offsets are APB byte addresses.
`default_nettype none
package pcp_pkg;

	localparam int PIX_W = 10;

	// Register byte offsets
	localparam logic [7:0] OFS_CTRL = 8'h00;
	localparam logic [7:0] OFS_BLACK_TOTAL = 8'h04;
	localparam logic [7:0] OFS_BLACK_SPLIT = 8'h08;
	localparam logic [7:0] OFS_WB_RED = 8'h0c;
	localparam logic [7:0] OFS_WB_BLUE = 8'h10;
	localparam logic [7:0] OFS_GAMMA_EXP = 8'h14;
	localparam logic [7:0] OFS_SHARP_AMT = 8'h18;
	localparam logic [7:0] OFS_SHARP_THR = 8'h1c;
	localparam logic [7:0] OFS_LUT_ADDR = 8'h20;
	localparam logic [7:0] OFS_LUT_DATA = 8'h24;
	localparam logic [7:0] OFS_STATUS = 8'h28;

	// Field positions
	localparam int CTRL_POWER_BIT = 0;
	localparam int CTRL_LUT_BIT = 1;
	localparam int CTRL_SHARP_BIT = 2;
	localparam int CTRL_SAUTO_BIT = 3;
	localparam int CTRL_WB_LSB = 4;
	localparam int SPLIT_DIG_LSB = 16;
	localparam int STATUS_THR_LSB = 16;

	// Reset values
	localparam logic [11:0] RST_BLACK = 12'h000;
	localparam logic [11:0] RST_RATIO = 12'h100;
	localparam logic [7:0] RST_GEXP = 8'h40;
	localparam logic [8:0] RST_AMT = 9'h020;
	localparam logic [7:0] RST_THR = 8'h08;

	// Limits and steps
	localparam logic [11:0] RATIO_UNITY = 12'h100;
	localparam logic [11:0] RATIO_MIN = 12'h010;
	localparam logic [11:0] RATIO_MAX = 12'hff0;
	localparam logic [11:0] RATIO_STEP = 12'h004;
	localparam logic [11:0] ANALOG_MAX = 12'h100;
	localparam logic [8:0] AMT_MAX = 9'h080;
	localparam logic [8:0] AMT_MIN = 9'h1f0;
	localparam logic [7:0] THR_MAX = 8'h40;
	localparam logic [9:0] THR_PIX_MAX = 10'h100;
	localparam logic [3:0] ONCE_ITER = 4'h8;
	localparam logic [9:0] PIX_FULL = 10'h3ff;

	// Colour tags on the pixel stream
	localparam logic [1:0] CH_RED = 2'h0;
	localparam logic [1:0] CH_GREEN = 2'h1;
	localparam logic [1:0] CH_BLUE = 2'h2;

	typedef enum logic [1:0] {
		WB_OFF,
		WB_ONCE,
		WB_CONT
	} pcp_wb_mode_t;

	typedef struct packed {
		logic valid;
		logic sof;
		logic eol;
		logic [1:0] chan;
		logic [PIX_W-1:0] data;
	} pcp_pix_t;

	typedef struct packed {
		logic power_curve_on;
		logic lut_on;
		logic sharp_on;
		logic sharp_auto;
		logic [11:0] bl_dig;
		logic [11:0] analog;
		logic [11:0] wb_r;
		logic [11:0] wb_b;
		logic [7:0] gexp;
		logic [8:0] amt;
		logic [7:0] thr;
	} pcp_cfg_t;

endpackage

`default_nettype wire

// >>> pcp_power_curve.sv
// Power-law stage: out = in ^ exponent on a normalised pixel, one cycle.
// Assumes exponent is unsigned 2.6 fixed point, steady for a whole frame.
`timescale 1ns/1ps
`default_nettype none

module pcp_power_curve (
	input wire logic clk_i,
	input wire logic arst_n_i,
	input wire logic en_i,
	input wire logic [7:0] exp_i,
	input wire pcp_pkg::pcp_pix_t pix_i,
	output pcp_pkg::pcp_pix_t pix_o
);

	typedef struct packed {
		pcp_pkg::pcp_pix_t pix;
	} pcp_pc_state_t;

	pcp_pc_state_t st_reg;
	pcp_pc_state_t st_next;

	// Approximate x^g through log2 and exp2 with linear mantissas
	function automatic logic [9:0] pcp_pow(input logic [9:0] x, input logic [7:0] g);
		logic [3:0] e;
		logic [9:0] norm;
		logic [11:0] lg;
		logic [19:0] prod;
		logic [5:0] sh;
		logic [7:0] q;
		logic [10:0] m;
		logic [10:0] res;
		e = 4'h0;
		for (int i = 0; i < 10; i++) begin
			if (x[i]) begin
				e = 4'(i);
			end
		end
		norm = x << (4'h9 - e);
		lg = {(4'ha - e), 8'h00} - {4'h0, norm[8:1]};
		prod = lg * g;
		sh = prod[19:14];
		q = prod[13:6];
		m = 11'h400 - {2'b00, q, 1'b0};
		res = (sh > 6'h0a) ? 11'h000 : (m >> sh);
		if (x == 10'h000) begin
			pcp_pow = 10'h000;
		end else if (res > {1'b0, pcp_pkg::PIX_FULL}) begin
			pcp_pow = pcp_pkg::PIX_FULL;
		end else begin
			pcp_pow = res[9:0];
		end
	endfunction

	always_comb begin
		st_next = st_reg;
		st_next.pix = pix_i;
		if (en_i) begin
			st_next.pix.data = pcp_pow(pix_i.data, exp_i);
		end
	end

	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			st_reg <= '0;
		end else begin
			st_reg <= st_next;
		end
	end

	assign pix_o = st_reg.pix;

endmodule

`default_nettype wire

// >>> pcp_sensor_model.sv
// Sensor readout model: sends one-line frames of eight pixels.
// Assumes the caller waits for the frame to drain before the next.
`timescale 1ns/1ps
`default_nettype none
module pcp_sensor_model (
	input wire logic clk_i,
	output pcp_pkg::pcp_pix_t pix_o
);
	initial pix_o = '0;
	task automatic send_frame(input logic [9:0] v [8], input logic [9:0] c [8]);
		for (int i = 0; i < 8; i++) begin
			@(posedge clk_i);
			pix_o <= '{1'b1, i == 0, i == 7, c[i][1:0], v[i]};
		end
		@(posedge clk_i);
		pix_o <= '{1'b0, 1'b0, 1'b0, ~c[7][1:0], ~v[7]};
	endtask
endmodule
`default_nettype wire
